// [otp_pkg.sv]
package otp_pkg;
    localparam int ARRAY_WORDS = 4096;
    localparam int BYTE_ADDR_W = 13;
    localparam int WORD_W = 16;
    localparam logic [15:0] BLANK_WORD = 16'hffff;
    localparam logic [31:0] APB_CTRL = 32'h0000_0000;
    localparam logic [31:0] APB_STATUS = 32'h0000_0004;
    localparam logic [31:0] APB_PROG_COUNT = 32'h0000_0008;
    localparam int PROT_ADDR_BIT = 4;
    localparam int PROT_VERIFY_ADDR_BIT = 6;
    localparam int FUSE_DATA_BIT = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_UP_MODE_BIT = 0;
    localparam int STAT_FUSE_BIT = 0;
    localparam int STAT_PROG_MODE_BIT = 1;
    localparam int STAT_UP_MODE_BIT = 2;
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_READ = 3'b001,
        MODE_VERIFY = 3'b011,
        MODE_PROGRAM = 3'b010,
        MODE_PROTECT = 3'b110,
        MODE_PROT_VERIFY = 3'b111
    } pin_mode_t;
endpackage

// [pin_sync_if.sv]
`timescale 1ns/100ps
interface pin_sync_if;
    logic chip_enable_n;
    logic output_gate_n;
    logic program_strobe_n;
    logic test_mode_select;
    logic [12:0] addr;
    logic [7:0] data;
    modport src (output chip_enable_n, output output_gate_n, output program_strobe_n, output test_mode_select,
                 output addr, output data);
    modport dst (input chip_enable_n, input output_gate_n, input program_strobe_n, input test_mode_select,
                 input addr, input data);
endinterface

// [pin_sync.sv]
`timescale 1ns/100ps
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_enable_n,
    input wire logic output_gate_n,
    input wire logic program_strobe_n,
    input wire logic test_mode_select,
    input wire logic [12:0] addr,
    input wire logic [7:0] data,
    pin_sync_if.src sync
);
    // Two stages; the first stage feeds nothing but the second
    logic [24:0] stage1;
    logic [24:0] stage2;
    logic [24:0] next_stage1;
    always_comb begin
        next_stage1 = {chip_enable_n, output_gate_n, program_strobe_n, test_mode_select, addr, data};
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels, so no mode is decoded while reset clears
            stage1 <= 25'h1c000ff;
            stage2 <= 25'h1c000ff;
        end else begin
            stage1 <= next_stage1;
            stage2 <= stage1;
        end
    end
    assign sync.chip_enable_n = stage2[24];
    assign sync.output_gate_n = stage2[23];
    assign sync.program_strobe_n = stage2[22];
    assign sync.test_mode_select = stage2[21];
    assign sync.addr = stage2[20:8];
    assign sync.data = stage2[7:0];
endmodule // pin_sync

// [otp_program_protect.sv]
// Functional notes
// - Array ships blank, every bit one
// - Byte-wide transfer on low data byte
// - Program mode: strobe low, gate high, enable low
// - Verify drives byte: gate, enable low, strobe high
// - No programming with enable or strobe high
// - Read drives addressed byte on low byte
// - Reads allowed only while fuse unprogrammed
// - Gate or enable high floats data byte
// - Fuse blocks readout and external-program mode
// - Fuse stays set until reset clears it
// - Fuse disconnects program bus from external mux
// - Protected: inbound moves work, outbound give nothing (here they give the data memory bus word)
// - Protected: multiply-accumulate cannot read external tables
// - Protect verify shows fuse inverted on bit 7
`timescale 1ns/100ps
module otp_program_protect
    import otp_pkg::*;
#(
    parameter int WORDS = ARRAY_WORDS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chip_enable_n,
    input wire logic output_gate_n,
    input wire logic program_strobe_n,
    input wire logic test_mode_select,
    input wire logic [12:0] addr,
    input wire logic [7:0] device_low_byte_in,
    output logic [7:0] device_low_byte_out,
    output logic [7:0] device_low_byte_oe,
    input wire logic [11:0] program_memory_addr,
    output logic [15:0] program_memory_bus,
    input wire logic [15:0] data_memory_bus,
    input wire logic ext_prog_to_ext_bus,
    output logic [15:0] external_bus_out,
    output logic external_up_mode,
    output logic mac_ext_table_enable,
    output logic outbound_prog_enable,
    output logic read_protect_fuse,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    pin_sync_if pins ();
    pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .chip_enable_n(chip_enable_n),
        .output_gate_n(output_gate_n),
        .program_strobe_n(program_strobe_n),
        .test_mode_select(test_mode_select),
        .addr(addr),
        .data(device_low_byte_in),
        .sync(pins.src)
    );

    // Byte-addressed view of the word array: even byte is low half
    logic [15:0] mem [WORDS];
    logic [11:0] word_idx;
    logic hi_sel;
    logic [7:0] cur_byte;
    assign word_idx = pins.addr[12:1];
    assign hi_sel = pins.addr[0];
    assign cur_byte = hi_sel ? mem[word_idx][15:8] : mem[word_idx][7:0];

    pin_mode_t mode;
    always_comb begin
        mode = MODE_IDLE;
        if (pins.test_mode_select && pins.chip_enable_n && pins.output_gate_n && pins.program_strobe_n
            && pins.addr[PROT_ADDR_BIT]) begin
            mode = MODE_PROTECT;
        end else if (pins.test_mode_select && !pins.chip_enable_n && !pins.output_gate_n
            && pins.program_strobe_n && !pins.addr[PROT_VERIFY_ADDR_BIT]) begin
            mode = MODE_PROT_VERIFY;
        end else if (!pins.chip_enable_n && pins.output_gate_n && !pins.program_strobe_n) begin
            mode = MODE_PROGRAM;
        end else if (!pins.chip_enable_n && !pins.output_gate_n && pins.program_strobe_n) begin
            mode = MODE_VERIFY;
        end
    end

    // Programming edge: only the strobe's falling edge, one pulse per strobe
    logic strobe_d;
    logic fuse_pulse_d;
    logic next_strobe_d;
    logic next_fuse_pulse_d;
    logic fuse;
    logic next_fuse;
    logic prog_now;
    logic fuse_now;
    logic [15:0] prog_count;
    logic [15:0] next_prog_count;
    always_comb begin
        next_strobe_d = pins.program_strobe_n;
        next_fuse_pulse_d = pins.data[FUSE_DATA_BIT];
        prog_now = (mode == MODE_PROGRAM) && strobe_d;
        fuse_now = (mode == MODE_PROTECT) && fuse_pulse_d && !pins.data[FUSE_DATA_BIT];
        next_fuse = fuse | fuse_now;
        next_prog_count = prog_now ? prog_count + 16'h0001 : prog_count;
    end

    // Cells only go from one to zero: programming ANDs data in
    integer i;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d <= 1'b1;
            fuse_pulse_d <= 1'b1;
            fuse <= 1'b0;
            prog_count <= 16'h0000;
        end else begin
            strobe_d <= next_strobe_d;
            fuse_pulse_d <= next_fuse_pulse_d;
            fuse <= next_fuse;
            prog_count <= next_prog_count;
        end
    end
    // Array contents survive reset; blank value loaded once at start
    initial begin
        for (i = 0; i < WORDS; i = i + 1) begin
            mem[i] = BLANK_WORD;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (prog_now) begin
            if (hi_sel) begin
                mem[word_idx][15:8] <= mem[word_idx][15:8] & pins.data;
            end else begin
                mem[word_idx][7:0] <= mem[word_idx][7:0] & pins.data;
            end
        end
    end

    // Pin data output; read outside programming blocked by fuse
    logic [7:0] next_out;
    logic [7:0] next_oe;
    always_comb begin
        next_out = 8'h00;
        next_oe = 8'h00;
        if (mode == MODE_PROT_VERIFY) begin
            next_out = {!fuse, 7'h00};
            next_oe = 8'h80;
        end else if (mode == MODE_VERIFY && !fuse) begin
            next_out = cur_byte;
            next_oe = 8'hff;
        end
    end

    // Internal program bus and external mux
    logic [15:0] next_program_memory_bus;
    logic [15:0] next_ext;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    always_comb begin
        next_program_memory_bus = mem[program_memory_addr];
        // Fuse isolates the program side; outbound copies give the data memory bus word
        if (ext_prog_to_ext_bus && !fuse) begin
            next_ext = mem[program_memory_addr];
        end else begin
            next_ext = data_memory_bus;
        end
    end

    // APB slave: zero wait, unmapped addresses give an error
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic wr_ok;
    always_comb begin
        next_ctrl = ctrl;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        wr_ok = psel && !penable;
        // Write lands only at the access edge that sees pready high
        if (psel && penable && pready && pwrite && paddr == APB_CTRL) begin
            next_ctrl = {31'h0, pwdata[CTRL_UP_MODE_BIT]};
        end
        if (wr_ok) begin
            case (paddr)
                APB_CTRL: begin
                    next_prdata = ctrl;
                end
                APB_STATUS: begin
                    next_prdata = 32'h0;
                    next_prdata[STAT_FUSE_BIT] = fuse;
                    next_prdata[STAT_PROG_MODE_BIT] = (mode == MODE_PROGRAM);
                    next_prdata[STAT_UP_MODE_BIT] = ctrl[CTRL_UP_MODE_BIT] && !fuse;
                    next_pslverr = pwrite;
                end
                APB_PROG_COUNT: begin
                    next_prdata = {16'h0, prog_count};
                    next_pslverr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            device_low_byte_out <= 8'h00;
            device_low_byte_oe <= 8'h00;
            program_memory_bus <= 16'h0000;
            external_bus_out <= 16'h0000;
            external_up_mode <= 1'b0;
            mac_ext_table_enable <= 1'b0;
            outbound_prog_enable <= 1'b0;
            read_protect_fuse <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            prdata <= wr_ok ? next_prdata : prdata;
            pready <= wr_ok;
            pslverr <= wr_ok && next_pslverr;
            device_low_byte_out <= next_out;
            device_low_byte_oe <= next_oe;
            program_memory_bus <= next_program_memory_bus;
            external_bus_out <= next_ext;
            external_up_mode <= ctrl[CTRL_UP_MODE_BIT] && !fuse;
            mac_ext_table_enable <= !fuse;
            outbound_prog_enable <= !fuse;
            read_protect_fuse <= fuse;
        end
    end
endmodule // otp_program_protect

// [otp_program_protect_sva.sv]
`timescale 1ns/100ps
module otp_program_protect_sva (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chip_enable_n,
    input wire logic output_gate_n,
    input wire logic [7:0] device_low_byte_oe,
    input wire logic [15:0] data_memory_bus,
    input wire logic [15:0] external_bus_out,
    input wire logic external_up_mode,
    input wire logic mac_ext_table_enable,
    input wire logic outbound_prog_enable,
    input wire logic read_protect_fuse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Five samples cover the two sync flops plus the output register
    oe_enable_a: assert property (chip_enable_n [*5] |-> device_low_byte_oe == 8'h00)
        else $error("byte driven with enable high");
    oe_gate_a: assert property (output_gate_n [*5] |-> device_low_byte_oe == 8'h00)
        else $error("byte driven with gate high");
    fuse_hold_a: assert property (read_protect_fuse |=> read_protect_fuse)
        else $error("fuse cleared");
    up_block_a: assert property (read_protect_fuse [*2] |-> !external_up_mode)
        else $error("external mode while protected");
    mac_block_a: assert property (read_protect_fuse [*2] |-> !mac_ext_table_enable)
        else $error("table read while protected");
    outbound_block_a: assert property (read_protect_fuse [*2] |-> !outbound_prog_enable)
        else $error("outbound move while protected");
    bus_isolate_a: assert property (read_protect_fuse [*2] |=> external_bus_out == $past(data_memory_bus))
        else $error("program word reached external bus");
    read_block_a: assert property (read_protect_fuse [*4] |-> device_low_byte_oe != 8'hff)
        else $error("byte read while protected");
endmodule // otp_program_protect_sva

bind otp_program_protect otp_program_protect_sva i_sva (.ref_clk, .nrst, .chip_enable_n, .output_gate_n,
    .device_low_byte_oe, .data_memory_bus, .external_bus_out, .external_up_mode, .mac_ext_table_enable,
    .outbound_prog_enable, .read_protect_fuse);

// [otp_programmer.sv]
`timescale 1ns/100ps
module otp_programmer (
    input wire logic ref_clk,
    input wire logic [7:0] q_out,
    input wire logic [7:0] q_oe,
    output logic ce_n,
    output logic g_n,
    output logic pgm_n,
    output logic tms,
    output logic [12:0] a,
    output logic [7:0] d
);
    logic failed;
    initial begin
        {ce_n, g_n, pgm_n, tms, a, d, failed} = {4'he, 13'h0000, 8'h00, 1'b0};
    end
    task automatic rd(input logic [12:0] ad, input logic t, output logic [7:0] v, output logic [7:0] e);
        a <= ad;
        tms <= t;
        ce_n <= 1'b0;
        pgm_n <= 1'b1;
        d <= ~d; // Lane released, show the inverse
        g_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        v = q_out;
        e = q_oe;
        g_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic prog(input logic [12:0] ad, input logic [7:0] val, input logic inhibit, input logic std);
        logic [7:0] v, e;
        int n;
        int lim;
        n = 0;
        lim = std ? 25 : 10;
        failed = 1'b0;
        v = 8'hff;
        while (v !== val && !failed) begin
            a <= ad;
            d <= val;
            tms <= 1'b0;
            ce_n <= inhibit;
            g_n <= 1'b1;
            repeat (4) @(posedge ref_clk);
            pgm_n <= 1'b0;
            repeat (4) @(posedge ref_clk);
            pgm_n <= 1'b1;
            @(posedge ref_clk);
            rd(ad, 1'b0, v, e);
            n++;
            failed = n >= lim && v !== val;
        end
        // Final pulse in scaled time: three strobe cycles per prime pulse
        if (std && !failed) begin
            d <= val;
            g_n <= 1'b1;
            ce_n <= inhibit;
            repeat (4) @(posedge ref_clk);
            pgm_n <= 1'b0;
            repeat (3 * n) @(posedge ref_clk);
            pgm_n <= 1'b1;
            @(posedge ref_clk);
        end
    endtask
    task automatic protect();
        ce_n <= 1'b1;
        g_n <= 1'b1;
        pgm_n <= 1'b1;
        tms <= 1'b1;
        a <= 13'h0010;
        d <= 8'h80;
        repeat (4) @(posedge ref_clk);
        d <= 8'h00;
        repeat (4) @(posedge ref_clk);
        d <= 8'h80;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // otp_programmer

// [otp_program_protect_tb.sv]
`timescale 1ns/100ps
module otp_program_protect_tb import otp_pkg::*; ;
    logic ref_clk = 1'b0, nrst = 1'b0, ext_prog_to_ext_bus = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, chip_enable_n, output_gate_n, program_strobe_n, test_mode_select;
    logic read_protect_fuse, external_up_mode, err;
    logic [12:0] addr;
    logic [7:0] device_low_byte_in, device_low_byte_out, device_low_byte_oe, v, e;
    logic [11:0] program_memory_addr = 12'h000;
    logic [15:0] program_memory_bus, external_bus_out, data_memory_bus = 16'h5a5a;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
    int mismatches = 0, check_count = 0;
    always #50 ref_clk = ~ref_clk;
    otp_program_protect i_dut (.ref_clk, .nrst, .chip_enable_n, .output_gate_n, .program_strobe_n,
        .test_mode_select, .addr, .device_low_byte_in, .device_low_byte_out, .device_low_byte_oe,
        .program_memory_addr, .program_memory_bus, .data_memory_bus, .ext_prog_to_ext_bus, .external_bus_out,
        .external_up_mode, .mac_ext_table_enable(), .outbound_prog_enable(), .read_protect_fuse, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    otp_programmer i_prog (.ref_clk, .q_out(device_low_byte_out), .q_oe(device_low_byte_oe),
        .ce_n(chip_enable_n), .g_n(output_gate_n), .pgm_n(program_strobe_n), .tms(test_mode_select),
        .a(addr), .d(device_low_byte_in));
    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
        int w;
        w = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        rv = prdata;
        err = pslverr;
        if (w >= 16) begin
            mismatches++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic t_regs();
        apb(1'b0, APB_CTRL, 32'h0);
        chk("ctrl reset", CTRL_RESET, rv);
        apb(1'b1, APB_STATUS, 32'h7);
        chk("status write error", 32'h1, {31'h0, err});
        apb(1'b1, 32'h0000_000c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, APB_CTRL, 32'h1);
        apb(1'b0, APB_CTRL, 32'h0);
        chk("ctrl", 32'h1, rv);
    endtask
    task automatic t_blank();
        i_prog.rd(13'h0005, 1'b0, v, e);
        chk("blank byte", 32'hff, {24'h0, v});
        chk("read enable", 32'hff, {24'h0, e});
        repeat (5) @(posedge ref_clk);
        chk("disabled", 32'h0, {24'h0, device_low_byte_oe});
    endtask
    task automatic t_prog();
        i_prog.prog(13'h0011, 8'h3c, 1'b0, 1'b0);
        i_prog.prog(13'h0010, 8'ha5, 1'b0, 1'b1);
        chk("program fail", 32'h0, {31'h0, i_prog.failed});
        i_prog.rd(13'h0011, 1'b0, v, e);
        chk("verify", 32'h3c, {24'h0, v});
        program_memory_addr <= 12'h008;
        ext_prog_to_ext_bus <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("program word", 32'h3ca5, {16'h0, program_memory_bus});
        chk("external word", 32'h3ca5, {16'h0, external_bus_out});
        chk("external mode", 32'h1, {31'h0, external_up_mode});
    endtask
    task automatic t_inhibit();
        i_prog.prog(13'h0020, 8'h00, 1'b1, 1'b0);
        chk("inhibit fail", 32'h1, {31'h0, i_prog.failed});
        i_prog.rd(13'h0020, 1'b0, v, e);
        chk("inhibited byte", 32'hff, {24'h0, v});
        apb(1'b0, APB_PROG_COUNT, 32'h0);
        chk("pulse count", 32'h3, rv);
    endtask
    task automatic t_protect();
        i_prog.protect();
        repeat (4) @(posedge ref_clk);
        chk("fuse", 32'h1, {31'h0, read_protect_fuse});
        chk("isolated bus", 32'h5a5a, {16'h0, external_bus_out});
        chk("external mode off", 32'h0, {31'h0, external_up_mode});
        i_prog.rd(13'h0010, 1'b0, v, e);
        chk("protected read", 32'h0, {24'h0, e});
        i_prog.rd(13'h0000, 1'b1, v, e);
        chk("fuse verify enable", 32'h80, {24'h0, e});
        chk("fuse verify bit", 32'h0, {31'h0, v[FUSE_DATA_BIT]});
        apb(1'b0, APB_STATUS, 32'h0);
        chk("status fuse", 32'h1, {31'h0, rv[STAT_FUSE_BIT]});
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs();
        t_blank();
        t_prog();
        t_inhibit();
        t_protect();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
endmodule // otp_program_protect_tb
